// *** rtl/wdit_regs.vh ***
`ifndef WDIT_REGS_VH
`define WDIT_REGS_VH
`define WDIT_CNT_W      15
`define WDIT_CLR_MSB    7
`define WDIT_CLR_LSB    4
`define WDIT_EN_BIT     3
`define WDIT_MODE_BIT   2
`define WDIT_INT_MSB    1
`define WDIT_INT_LSB    0
`define WDIT_CTL_RST    8'h00
`define WDIT_CODE_A     4'hA
`define WDIT_CODE_B     4'h5
`define WDIT_TC_00      16'h8000
`define WDIT_TC_01      16'h2000
`define WDIT_TC_10      16'h0200
`define WDIT_TC_11      16'h0040
`define WDIT_PM_ACTIVE  3'h0
`define WDIT_PM_ZERO    3'h1
`define WDIT_PM_ONE     3'h2
`define WDIT_PM_TWO     3'h3
`define WDIT_PM_THREE   3'h4
`define WDIT_SEQ_IDLE   1'h0
`define WDIT_SEQ_ARMED  1'h1
`endif

// *** rtl/wdit_tick_sync.v ***
module wdit_tick_sync
(
  // clock and reset
  input  wire clk_sys,
  input  wire sys_rst,
  // low-speed oscillator level
  input  wire osc_in,
  // one-cycle pulse per rising edge, and per falling edge
  output reg  rise_pulse,
  output reg  fall_pulse
);
  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      last_reg   <= 1'b0;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end
    else
    begin
      sync1_reg  <= osc_in;
      sync2_reg  <= sync1_reg;
      last_reg   <= sync2_reg;
      rise_pulse <= sync2_reg & ~last_reg;
      fall_pulse <= ~sync2_reg & last_reg;
    end
  end
endmodule // wdit_tick_sync

// *** rtl/wdit_term_sel.v ***
`include "wdit_regs.vh"
module wdit_term_sel
(
  // interval code and terminal count
  input  wire [1:0]  interval_code,
  output reg  [15:0] term_count
);
  always @*
  begin
    case (interval_code)
      2'h0:    term_count = `WDIT_TC_00;
      2'h1:    term_count = `WDIT_TC_01;
      2'h2:    term_count = `WDIT_TC_10;
      2'h3:    term_count = `WDIT_TC_11;
      default: term_count = `WDIT_TC_00;
    endcase
  end
endmodule // wdit_term_sel

// *** rtl/wdit_top.v ***
`include "wdit_regs.vh"
module wdit_top
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // low-speed oscillator
  input  wire       osc_in,
  // control register write port
  input  wire       ctl_wr,
  input  wire [7:0] ctl_wdata,
  // power mode
  input  wire [2:0] power_mode,
  // interval flag clear and interrupt enable
  input  wire       flag_clr,
  input  wire       interval_irq_enable,
  // outputs
  output reg  [7:0] watchdog_control_reg,
  output reg        interval_flag,
  output reg        irq_req,
  output reg        sys_reset_req
);
  reg  [`WDIT_CNT_W-1:0] count_reg;
  reg  [`WDIT_CNT_W-1:0] count_next;
  reg                    seq_reg;
  reg                    seq_next;
  reg                    lock_reg;
  reg                    pend_reg;
  reg                    pend_next;
  reg  [2:0]             pm_last_reg;
  reg  [7:0]             ctl_next;
  reg                    expire;
  reg                    set_flag;
  reg                    do_reset;
  reg                    lock_next;
  wire                   tick;
  wire                   half_tick;
  wire [15:0]            term_count;
  wire                   en_bit;
  wire                   mode_bit;
  wire [3:0]             code_w;
  wire                   sleep_deep;
  wire                   deep_entry;
  wire                   pm1;
  wire                   wake_pm1;

  assign en_bit     = watchdog_control_reg[`WDIT_EN_BIT];
  assign mode_bit   = watchdog_control_reg[`WDIT_MODE_BIT];
  assign code_w     = ctl_wdata[`WDIT_CLR_MSB:`WDIT_CLR_LSB];
  assign sleep_deep = (power_mode == `WDIT_PM_TWO) || (power_mode == `WDIT_PM_THREE);
  assign deep_entry = sleep_deep && (pm_last_reg != `WDIT_PM_TWO)
                      && (pm_last_reg != `WDIT_PM_THREE);
  assign pm1        = (power_mode == `WDIT_PM_ONE);
  assign wake_pm1   = (pm_last_reg == `WDIT_PM_ONE) && !pm1 && !sleep_deep;

  // oscillator edges: rise advances the counter, fall bounds the clear window
  wdit_tick_sync u_tick
  (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .osc_in     (osc_in),
    .rise_pulse (tick),
    .fall_pulse (half_tick)
  );

  wdit_term_sel u_term
  (
    .interval_code (watchdog_control_reg[`WDIT_INT_MSB:`WDIT_INT_LSB]),
    .term_count    (term_count)
  );

  always @*
  begin
    ctl_next   = watchdog_control_reg;
    count_next = count_reg;
    seq_next   = seq_reg;
    lock_next  = lock_reg;
    pend_next  = pend_reg;
    set_flag   = 1'b0;
    do_reset   = 1'b0;
    // counter is never exposed nor loaded by software
    expire = en_bit && tick && !sleep_deep
             && ({1'b0, count_reg} + 16'h0001 >= term_count);
    if (en_bit && tick && !sleep_deep)
    begin
      count_next = count_reg + 15'h0001;
      if (expire)
      begin
        if (mode_bit)
        begin
          count_next = {`WDIT_CNT_W{1'b0}};
          set_flag   = 1'b1;
        end
        else if (pm1)
        begin
          count_next = {`WDIT_CNT_W{1'b0}};
          pend_next  = 1'b1;
        end
        else
          do_reset = 1'b1;
      end
    end
    // clear window closes at the next falling oscillator edge
    if (half_tick)
      seq_next = `WDIT_SEQ_IDLE;
    if (ctl_wr)
    begin
      ctl_next[`WDIT_INT_MSB:`WDIT_INT_LSB] = ctl_wdata[`WDIT_INT_MSB:`WDIT_INT_LSB];
      if (!lock_reg)
        ctl_next[`WDIT_MODE_BIT] = ctl_wdata[`WDIT_MODE_BIT];
      if (ctl_wdata[`WDIT_EN_BIT])
      begin
        ctl_next[`WDIT_EN_BIT] = 1'b1;
        if (!en_bit)
          count_next = {`WDIT_CNT_W{1'b0}};
        if (!(lock_reg ? 1'b0 : ctl_wdata[`WDIT_MODE_BIT]))
          lock_next = 1'b1;
      end
      else if (!lock_reg)
        ctl_next[`WDIT_EN_BIT] = 1'b0;
      // clear code acts only while enabled
      if (en_bit)
      begin
        ctl_next[`WDIT_CLR_MSB:`WDIT_CLR_LSB] = code_w;
        if (mode_bit)
        begin
          if (code_w[0])
            count_next = {`WDIT_CNT_W{1'b0}};
        end
        else if (code_w == `WDIT_CODE_A)
          seq_next = `WDIT_SEQ_ARMED;
        else if ((code_w == `WDIT_CODE_B) && (seq_reg == `WDIT_SEQ_ARMED))
        begin
          count_next = {`WDIT_CNT_W{1'b0}};
          pend_next  = 1'b0;
          seq_next   = `WDIT_SEQ_IDLE;
          do_reset   = 1'b0;
        end
        else
          seq_next = `WDIT_SEQ_IDLE;
      end
    end
    // power mode one wake at expiry resets at once
    if (wake_pm1 && pend_reg && !mode_bit)
    begin
      do_reset  = 1'b1;
      pend_next = 1'b0;
    end
    if (sleep_deep)
    begin
      count_next = {`WDIT_CNT_W{1'b0}};
      seq_next   = `WDIT_SEQ_IDLE;
      pend_next  = 1'b0;
    end
    if (deep_entry)
      count_next = {`WDIT_CNT_W{1'b0}};
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      watchdog_control_reg <= `WDIT_CTL_RST;
      count_reg            <= {`WDIT_CNT_W{1'b0}};
      seq_reg              <= `WDIT_SEQ_IDLE;
      lock_reg             <= 1'b0;
      pend_reg             <= 1'b0;
      pm_last_reg          <= `WDIT_PM_ACTIVE;
      interval_flag        <= 1'b0;
      irq_req              <= 1'b0;
      sys_reset_req        <= 1'b0;
    end
    else
    begin
      watchdog_control_reg <= ctl_next;
      count_reg            <= count_next;
      seq_reg              <= seq_next;
      lock_reg             <= lock_next;
      pend_reg             <= pend_next;
      pm_last_reg          <= power_mode;
      // set wins over clear
      interval_flag        <= set_flag | (interval_flag & ~flag_clr);
      // watchdog mode never interrupts
      irq_req              <= set_flag & interval_irq_enable & mode_bit;
      // reset only from watchdog mode, active or power mode zero
      sys_reset_req        <= do_reset & ~mode_bit;
    end
  end
endmodule // wdit_top

// *** sim/wdit_checker.sv ***
module wdit_checker
(
  // clock and reset
  input wire       clk_sys,
  input wire       sys_rst,
  // watched ports
  input wire       ctl_wr,
  input wire [7:0] ctl_wdata,
  input wire [2:0] power_mode,
  input wire [7:0] watchdog_control_reg,
  input wire       interval_flag,
  input wire       irq_req,
  input wire       sys_reset_req
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  wire wd_on = watchdog_control_reg[3] && !watchdog_control_reg[2];
  // unlock code, then its partner within two cycles
  sequence seq_clear;
    ctl_wr && ctl_wdata[7:4] == 4'hA && wd_on ##[1:2] ctl_wr && ctl_wdata[7:4] == 4'h5;
  endsequence
  chk_reset_zero:
    assert property ($fell(sys_rst) |-> !watchdog_control_reg && !interval_flag && !sys_reset_req)
    else $error("outputs not zero after reset");
  chk_irq_single:
    assert property (irq_req |=> !irq_req) else $error("interrupt too long");
  chk_irq_timer:
    assert property (irq_req |-> watchdog_control_reg[2] && interval_flag)
    else $error("interrupt outside timer mode");
  chk_reset_single:
    assert property (sys_reset_req |=> !sys_reset_req) else $error("reset request too long");
  chk_timer_noreset:
    assert property ($past(watchdog_control_reg[2]) |-> !sys_reset_req)
    else $error("reset request in timer mode");
  chk_mode_lock:
    assert property (wd_on |=> wd_on) else $error("watchdog left enabled mode");
  chk_code_ignored:
    assert property (ctl_wr && !ctl_wdata[3] && !watchdog_control_reg[3]
      |=> $stable(watchdog_control_reg[7:4])) else $error("clear code stored while off");
  chk_sleep_quiet:
    assert property ($past(power_mode) >= 3'h2 && power_mode >= 3'h2 |-> !sys_reset_req)
    else $error("reset request in sleep mode");
  chk_clear_holds:
    assert property (seq_clear |-> ##2 !sys_reset_req [*8]) else $error("reset after clear");
endmodule // wdit_checker

// *** sim/wdit_top_test.sv ***
module wdit_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys, sys_rst, osc_in, ctl_wr, flag_clr, irq_en, irq_seen;
  logic [7:0] ctl_wdata;
  logic [2:0] power_mode;
  wire  [7:0] watchdog_control_reg;
  wire        interval_flag, irq_req, sys_reset_req;
  int         errors, checks_done, ticks, phase, t0, t2;

  wdit_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .osc_in(osc_in), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .power_mode(power_mode), .flag_clr(flag_clr),
    .interval_irq_enable(irq_en), .watchdog_control_reg(watchdog_control_reg),
    .interval_flag(interval_flag), .irq_req(irq_req), .sys_reset_req(sys_reset_req));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // eight-cycle oscillator, rising at phase zero
  always @(posedge clk_sys)
  begin
    #1;
    phase = (phase + 1) % 8;
    osc_in = phase < 4;
    ticks += phase == 0;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // also returns from sleep with the write
  task automatic wr(input logic [7:0] d);
    step(1);
    ctl_wr = 1'b1;
    ctl_wdata = d;
    power_mode = 3'h0;
    step(1);
    ctl_wr = 1'b0;
  endtask
  task automatic do_reset;
    step(1);
    sys_rst = 1'b1;
    step(16);
    sys_rst = 1'b0;
  endtask
  // write just after a rising oscillator edge
  task automatic arm(input logic [7:0] d);
    do
    begin
      @(posedge clk_sys);
      #2;
    end
    while (phase != 0);
    t0 = ticks;
    wr(d);
  endtask
  task automatic expect_at(input logic on_reset, input logic [15:0] want);
    int n = 0;
    do
    begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    while (n < 6000 && (on_reset ? sys_reset_req : irq_req) !== 1'b1);
    check(16'(ticks - t0), want);
  endtask
  task automatic summarize;
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    errors++;
    summarize;
  end
  initial
  begin
    {sys_rst, osc_in, ctl_wr, flag_clr} = 4'h8;
    irq_en = 1'b1;
    ctl_wdata = 8'h00;
    power_mode = 3'h0;
    do_reset;
    check(watchdog_control_reg, 8'h00);
    wr(8'hA0);
    check(watchdog_control_reg, 8'h00);
    for (int c = 2; c < 4; c++)
    begin
      do_reset;
      arm({6'h03, c[1:0]});
      expect_at(1'b0, (16'h0040 << (3 * (3 - c))) - 16'h0001);
    end
    t0 = ticks;
    expect_at(1'b0, 16'h0040);
    step(1);
    flag_clr = 1'b1;
    wr(8'h07);
    flag_clr = 1'b0;
    check(watchdog_control_reg, 8'h07);
    step(800);
    check(interval_flag, 1'b0);
    arm(8'h0F);
    expect_at(1'b0, 16'h003F);
    step(320);
    arm(8'h1F);
    expect_at(1'b0, 16'h003F);
    // interrupt masked: flag still set at the next terminal count
    irq_en = 1'b0;
    flag_clr = 1'b1;
    step(1);
    flag_clr = 1'b0;
    irq_seen = 1'b0;
    repeat (560)
    begin
      step(1);
      irq_seen = irq_seen | irq_req;
    end
    check(irq_seen, 1'b0);
    check(interval_flag, 1'b1);
    irq_en = 1'b1;
    do_reset;
    arm(8'h0B);
    wr(8'h03);
    check(watchdog_control_reg, 8'h0B);
    wr(8'h06);
    check(watchdog_control_reg, 8'h0A);
    wr(8'h0B);
    // clear after the interval change; the tick of the clear edge is lost
    arm(8'hAB);
    wr(8'h5B);
    expect_at(1'b1, 16'h0040);
    check(interval_flag, 1'b0);
    // good clear, aborted clear, sleep in power mode two
    for (int k = 0; k < 3; k++)
    begin
      do_reset;
      arm(8'h0B);
      t2 = t0;
      step(320);
      power_mode = (k == 2) ? 3'h3 : 3'h0;
      step(40);
      arm((k == 2) ? 8'h0B : 8'hAB);
      if (k == 1)
        wr(8'h3B);
      wr(8'h5B);
      if (k == 1)
        t0 = t2;
      // a good clear lands on a tick edge and swallows that tick
      expect_at(1'b1, (k == 0) ? 16'h0040 : 16'h003F);
    end
    summarize;
  end
endmodule // wdit_top_test

bind wdit_top wdit_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctl_wr(ctl_wr),
  .ctl_wdata(ctl_wdata), .power_mode(power_mode), .watchdog_control_reg(watchdog_control_reg),
  .interval_flag(interval_flag), .irq_req(irq_req), .sys_reset_req(sys_reset_req));
